// ---- rtl/msh_pkg.sv ----
// Constants and types shared by the multiplier and shifter datapath
package msh_pkg;

   // ----------------------------------------------------------------
   // Datapath widths
   // ----------------------------------------------------------------
   localparam int MSH_COEF_W = 16;
   localparam int MSH_DATA_W = 24;
   localparam int MSH_FULL_W = 40;
   localparam int MSH_PROD_W = 31;
   localparam int MSH_OUT_W = 34;
   localparam int MSH_CNT_W = 5;

   // ----------------------------------------------------------------
   // Field positions inside the 34-bit shifter frame
   // ----------------------------------------------------------------
   localparam int MSH_PROD_LSB = 9;
   localparam int MSH_PROD_EXT = 3;
   localparam int MSH_BUS_EXT = 4;
   localparam int MSH_BUS_PAD = 6;
   localparam int MSH_DP_SHIFT = 15;
   localparam int MSH_DP_TOP = 13;
   localparam int MSH_DP_LOW = 6;
   localparam int MSH_CNT_MSB = 23;

   // ----------------------------------------------------------------
   // Timing and reset values
   // ----------------------------------------------------------------
   localparam int MSH_MUL_LAT = 2;
   localparam logic [MSH_CNT_W-1:0] MSH_CNT_RST = 5'h00;
   localparam logic [MSH_OUT_W-1:0] MSH_OUT_RST = 34'h000000000;

   // Shift operation selected by the microprogram word
   typedef enum logic [1:0]
   {
      MSH_DIRECT,
      MSH_DPL,
      MSH_DPR
   } msh_mode_t;

   // Direct shift code 0..7 maps onto 0,1,2,3,4,6,8,15 positions
   function automatic logic [3:0] msh_amount(input logic [2:0] code);
      logic [3:0] amt;
      amt = 4'h0;
      unique case (code)
         3'h0: amt = 4'h0;
         3'h1: amt = 4'h1;
         3'h2: amt = 4'h2;
         3'h3: amt = 4'h3;
         3'h4: amt = 4'h4;
         3'h5: amt = 4'h6;
         3'h6: amt = 4'h8;
         3'h7: amt = 4'hF;
      endcase
      return amt;
   endfunction : msh_amount

endpackage : msh_pkg

// ---- rtl/msh_mult.sv ----
// Two-stage signed 24x16 multiplier with one extra sign bit on the result
`timescale 1ns/1ps
module msh_mult
   import msh_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Operands
   input wire logic [MSH_DATA_W-1:0] data_op_i,
   input wire logic [MSH_COEF_W-1:0] coef_op_i,
   // Result
   output logic [MSH_PROD_W-1:0] product_o
);

   logic [MSH_DATA_W-1:0] data_q, data_d;
   logic [MSH_COEF_W-1:0] coef_q, coef_d;
   logic [MSH_PROD_W-1:0] prod_q, prod_d;
   logic signed [MSH_FULL_W-1:0] full;

   // ----------------------------------------------------------------
   // Pipeline: operand stage, then product stage
   // ----------------------------------------------------------------
   // Full 40-bit product; its top bit is the headroom copy of the sign
   always_comb
   begin
      data_d = data_op_i;
      coef_d = coef_op_i;
      full = $signed(data_q) * $signed(coef_q);
      prod_d = full[MSH_FULL_W-1:MSH_PROD_LSB];
   end

   // Two registers give the product two edges after the operands
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_q <= '0;
         coef_q <= '0;
         prod_q <= '0;
      end
      else
      begin
         data_q <= data_d;
         coef_q <= coef_d;
         prod_q <= prod_d;
      end
   end

   assign product_o = prod_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_mul_latency;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      ##2 1'b1 |-> (product_o == MSH_PROD_W'((MSH_FULL_W'($signed($past(data_op_i, 2)))
         * MSH_FULL_W'($signed($past(coef_op_i, 2)))) >>> MSH_PROD_LSB));
   endproperty
   a_mul_latency: assert property (p_mul_latency)
      else $error("product not the signed result two cycles later");

endmodule : msh_mult

// ---- rtl/msh_top.sv ----
// Multiplier operand select, barrel shifter and indirect shift count
//
// Overview of operation
// - Multiply signed 24-bit data by 16-bit coefficient, pass 31-bit result on.
// - Coefficient from memory or bus, data from memory or bus, any pairing.
// - Product keeps one extra sign bit so minus one squared fits.
// - Product appears two clock cycles after its operands.
// - 24x31 multiply: high-coefficient product added 15 bits left of low.
// - 45-bit multiply: upper and lower sums formed apart, lower added in.
// - 45x31: high-high upper 24 bits to upper sum, low 15 shifted left.
// - 45x31: cross and low products summed in first accumulator, shifted.
// - 45x31: 34-bit lower sum shifted 15 right, added to upper sum.
// - 45x16: same split, data-low product shifted 6 right, 24+21 bits.
// - Shifter takes product or bus, sign-fills top, zero-fills bottom of bus only, 34 bits.
// - Direct shifts right or left by 0,1,2,3,4,6,8,15; plus indirect.
// - Product path of shifter is 31 bits, one bit of overflow headroom.
// - Left shifts never saturate; large shifts may lose the sign bit.
// - Double-precision left shift: low 15 product bits moved 6 left, rest zero.
// - After that shift, the product's low 6 bits read zero next step.
// - Double-precision right shift: accumulator shifted 15 right, low 6 zero.
// - That right shift always reads first accumulator over a wired path.
// - Indirect count loads from top 5 bus bits, overrides next step once if that step is a direct shift.
// - Indirect count low four bits give right shift 0..15; top bit ignored.
`timescale 1ns/1ps
module msh_top
   import msh_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Operand sources
   input wire logic [MSH_COEF_W-1:0] coefficient_memory_i,
   input wire logic [MSH_DATA_W-1:0] data_memory_i,
   input wire logic [MSH_DATA_W-1:0] internal_data_bus_i,
   input wire logic coef_from_bus_i,
   input wire logic data_from_bus_i,
   // Shift control from the microprogram word
   input wire logic bus_data_shift_cmd_i,
   input wire logic shift_left_i,
   input wire logic [2:0] shift_code_i,
   input wire msh_mode_t shift_mode_i,
   input wire logic set_indirect_shift_count_i,
   // Wired path from the first accumulator register
   input wire logic [MSH_OUT_W-1:0] first_accumulator_reg_i,
   // Results
   output logic [MSH_PROD_W-1:0] product_o,
   output logic [MSH_OUT_W-1:0] shift_out_o,
   output logic [MSH_CNT_W-1:0] indirect_count_o
);

   // ----------------------------------------------------------------
   // Operand selection and multiplier
   // ----------------------------------------------------------------
   logic [MSH_COEF_W-1:0] coef_op;
   logic [MSH_DATA_W-1:0] data_op;
   logic [MSH_PROD_W-1:0] product;

   // Bus times bus is legal and gives a square
   always_comb
   begin
      coef_op = coef_from_bus_i ? internal_data_bus_i[MSH_DATA_W-1 -: MSH_COEF_W]
                                : coefficient_memory_i;
      data_op = data_from_bus_i ? internal_data_bus_i : data_memory_i;
   end

   msh_mult msh_mult_i
   (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .data_op_i(data_op),
      .coef_op_i(coef_op),
      .product_o(product)
   );

   assign product_o = product;

   // ----------------------------------------------------------------
   // Indirect count and sequencing state
   // ----------------------------------------------------------------
   logic [MSH_CNT_W-1:0] cnt_q, cnt_d;
   logic pend_q, pend_d;
   logic zero_q, zero_d;

   // The count is held, but pend_q lets it steer one step only: a stale count must never steer later shifts
   always_comb
   begin
      cnt_d = cnt_q;
      if (set_indirect_shift_count_i)
      begin
         cnt_d = internal_data_bus_i[MSH_CNT_MSB -: MSH_CNT_W];
      end
      pend_d = set_indirect_shift_count_i;
      zero_d = (shift_mode_i == MSH_DPL);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_q <= MSH_CNT_RST;
         pend_q <= 1'b0;
         zero_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         zero_q <= zero_d;
      end
   end

   assign indirect_count_o = cnt_q;

   // ----------------------------------------------------------------
   // Source framing into 34 bits
   // ----------------------------------------------------------------
   logic [MSH_PROD_W-1:0] prod_used;
   logic [MSH_OUT_W-1:0] prod_frame;
   logic [MSH_OUT_W-1:0] bus_frame;
   logic [MSH_OUT_W-1:0] src_frame;

   // Product keeps its headroom bit, so only three copies of sign are added
   always_comb
   begin
      prod_used = product;
      if (zero_q)
      begin
         prod_used[MSH_DP_LOW-1:0] = '0;
      end
      prod_frame = {{MSH_PROD_EXT{prod_used[MSH_PROD_W-1]}}, prod_used};
      bus_frame = {{MSH_BUS_EXT{internal_data_bus_i[MSH_DATA_W-1]}},
                   internal_data_bus_i, {MSH_BUS_PAD{1'b0}}};
      src_frame = bus_data_shift_cmd_i ? bus_frame : prod_frame;
   end

   // ----------------------------------------------------------------
   // Barrel shifter and output register
   // ----------------------------------------------------------------
   logic [MSH_OUT_W-1:0] out_q, out_d;
   logic [3:0] amt;

   // Left shifts simply drop bits off the top; no saturation is applied
   always_comb
   begin
      amt = msh_amount(shift_code_i);
      out_d = src_frame;
      unique case (shift_mode_i)
         MSH_DIRECT:
         begin
            if (pend_q)
            begin
               out_d = MSH_OUT_W'($signed(src_frame) >>> cnt_q[3:0]);
            end
            else if (shift_left_i)
            begin
               out_d = src_frame << amt;
            end
            else
            begin
               out_d = MSH_OUT_W'($signed(src_frame) >>> amt);
            end
         end
         MSH_DPL:
         begin
            out_d = {{MSH_DP_TOP{1'b0}}, product[MSH_DP_SHIFT-1:0],
                     {MSH_DP_LOW{1'b0}}};
         end
         MSH_DPR:
         begin
            // Accumulator is read here whatever register the word names
            out_d = MSH_OUT_W'($signed(first_accumulator_reg_i) >>> MSH_DP_SHIFT);
            out_d[MSH_DP_LOW-1:0] = '0;
         end
         default:
         begin
            out_d = src_frame;
         end
      endcase
   end

   // Registered so the value meets the ALU accumulate of the same line
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         out_q <= MSH_OUT_RST;
      end
      else
      begin
         out_q <= out_d;
      end
   end

   assign shift_out_o = out_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [3:0] bus_cnt_bits;
   logic direct_plain;
   assign bus_cnt_bits = internal_data_bus_i[MSH_CNT_MSB-1 -: 4];
   assign direct_plain = (shift_mode_i == MSH_DIRECT) && !pend_q;

   sequence s_set_then_direct;
      set_indirect_shift_count_i ##1 (shift_mode_i == MSH_DIRECT);
   endsequence

   sequence s_dpl_step;
      shift_mode_i == MSH_DPL;
   endsequence

   property p_minus_one_sq;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (coef_op == 16'h8000 && data_op == 24'h800000) |-> ##2
         (product_o == 31'h20000000);
   endproperty
   a_minus_one_sq: assert property (p_minus_one_sq)
      else $error("minus one squared wrapped");

   property p_bus_square;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (coef_from_bus_i && data_from_bus_i && internal_data_bus_i == 24'h400000)
         |-> ##2 (product_o == 31'h08000000);
   endproperty
   a_bus_square: assert property (p_bus_square)
      else $error("bus squaring gave wrong product");

   property p_bus_frame;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (direct_plain && bus_data_shift_cmd_i && !shift_left_i && shift_code_i == 3'h0)
         |=> (shift_out_o == {{4{$past(internal_data_bus_i[23])}},
                              $past(internal_data_bus_i), 6'h00});
   endproperty
   a_bus_frame: assert property (p_bus_frame)
      else $error("bus data not framed to 34 bits");

   property p_right15;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (direct_plain && !shift_left_i && shift_code_i == 3'h7)
         |=> (shift_out_o == MSH_OUT_W'($signed($past(src_frame)) >>> 15));
   endproperty
   a_right15: assert property (p_right15)
      else $error("right shift by 15 wrong");

   property p_left_nosat;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (direct_plain && shift_left_i && shift_code_i == 3'h5)
         |=> (shift_out_o == ($past(src_frame) << 6));
   endproperty
   a_left_nosat: assert property (p_left_nosat)
      else $error("left shift by 6 saturated or wrong");

   // The high-coefficient partial product needs a full 15-position left offset
   property p_left15;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (direct_plain && shift_left_i && shift_code_i == 3'h7 && !bus_data_shift_cmd_i)
         |=> (shift_out_o == ($past(prod_frame) << 15));
   endproperty
   a_left15: assert property (p_left15)
      else $error("product left shift by 15 wrong");

   property p_cnt_load;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      set_indirect_shift_count_i |=>
         (indirect_count_o == $past(internal_data_bus_i[MSH_CNT_MSB -: MSH_CNT_W]));
   endproperty
   a_cnt_load: assert property (p_cnt_load)
      else $error("indirect count not loaded from top bus bits");

   property p_indirect;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_set_then_direct |=> (shift_out_o ==
         MSH_OUT_W'($signed($past(src_frame)) >>> $past(bus_cnt_bits, 2)));
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect count not applied in next step");

   property p_indirect_once;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (set_indirect_shift_count_i ##1 !set_indirect_shift_count_i) |=> !pend_q;
   endproperty
   a_indirect_once: assert property (p_indirect_once)
      else $error("indirect count applied more than one step");

   property p_dpl;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_dpl_step |=> (shift_out_o[33:21] == 13'h0000 && shift_out_o[5:0] == 6'h00
                      && shift_out_o[20:6] == $past(product[14:0]));
   endproperty
   a_dpl: assert property (p_dpl)
      else $error("double-precision left shift wrong");

   property p_dpl_zero;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      s_dpl_step ##1 (shift_mode_i == MSH_DIRECT && !bus_data_shift_cmd_i)
         |-> (prod_frame[5:0] == 6'h00);
   endproperty
   a_dpl_zero: assert property (p_dpl_zero)
      else $error("product low bits not cleared after left special shift");

   property p_dpr;
      @(posedge ref_clk_i) disable iff (!resetn_i)
      (shift_mode_i == MSH_DPR) |=> (shift_out_o[5:0] == 6'h00 &&
         shift_out_o[33:6] == 28'(($signed($past(first_accumulator_reg_i)) >>> 15) >>> 6));
   endproperty
   a_dpr: assert property (p_dpr)
      else $error("double-precision right shift wrong");

endmodule : msh_top

// ---- tb/msh_alu_model.sv ----
// Accumulator side of the datapath: the ALU register fed by the shifter
`timescale 1ns/1ps
module msh_alu_model
   import msh_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Accumulate control and shifter result
   input wire logic acc_clr_i,
   input wire logic acc_en_i,
   input wire logic [MSH_OUT_W-1:0] shift_out_i,
   // Wired accumulator value back to the shifter
   output logic [MSH_OUT_W-1:0] first_accumulator_reg_o
);
   logic [MSH_OUT_W-1:0] acc_q;
   logic [MSH_OUT_W-1:0] acc_d;

   // Partial sums add without saturation; keeping headroom is the program's job
   always_comb
   begin
      acc_d = acc_q;
      if (acc_clr_i)
      begin
         acc_d = MSH_OUT_RST;
      end
      else if (acc_en_i)
      begin
         acc_d = acc_q + shift_out_i;
      end
   end

   // Accumulator register
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         acc_q <= MSH_OUT_RST;
      end
      else
      begin
         acc_q <= acc_d;
      end
   end

   assign first_accumulator_reg_o = acc_q;
endmodule : msh_alu_model

// ---- tb/test_msh_top.sv ----
// Self-checking bench for the multiplier and shifter datapath
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); \
      end \
   end
module test_msh_top;
   import msh_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] cm = 16'h0000;
   logic [23:0] dm = 24'h000000;
   logic [23:0] bus = 24'h000000;
   logic cfb = 1'b0;
   logic dfb = 1'b0;
   logic bsc = 1'b0;
   logic sl = 1'b0;
   logic [2:0] sc = 3'h0;
   msh_mode_t mode = MSH_DIRECT;
   logic sis = 1'b0;
   logic acc_clr = 1'b0;
   logic acc_en = 1'b0;
   logic [33:0] acc;
   logic [30:0] prod;
   logic [33:0] sout;
   logic [4:0] icnt;
   int fail_count = 0;
   int num_checks = 0;
   localparam logic [3:0] AMT [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hF};

   // Clock at 50 MHz
   always #10 clk = ~clk;

   msh_top msh_top_i (.ref_clk_i(clk), .resetn_i(rst_n), .coefficient_memory_i(cm),
      .data_memory_i(dm), .internal_data_bus_i(bus), .coef_from_bus_i(cfb),
      .data_from_bus_i(dfb), .bus_data_shift_cmd_i(bsc), .shift_left_i(sl),
      .shift_code_i(sc), .shift_mode_i(mode), .set_indirect_shift_count_i(sis),
      .first_accumulator_reg_i(acc), .product_o(prod), .shift_out_o(sout),
      .indirect_count_o(icnt));
   msh_alu_model msh_alu_model_i (.ref_clk_i(clk), .resetn_i(rst_n), .acc_clr_i(acc_clr),
      .acc_en_i(acc_en), .shift_out_i(sout), .first_accumulator_reg_o(acc));

   // ------------------------------------------------------------
   // Reference arithmetic
   // ------------------------------------------------------------
   function automatic logic [30:0] f_prod(input logic [23:0] d, input logic [15:0] c);
      logic signed [39:0] full;
      full = $signed(d) * $signed(c);
      return full[39:9];
   endfunction : f_prod

   function automatic logic [33:0] fr(input logic [30:0] p);
      return {{3{p[30]}}, p};
   endfunction : fr

   function automatic logic [33:0] fb(input logic [23:0] b);
      return {{4{b[23]}}, b, 6'h00};
   endfunction : fb

   // Right shifts computed apart so the conditional cannot turn them logical
   function automatic logic [33:0] shx(input logic [33:0] f, input logic l, input logic [3:0] n);
      logic signed [33:0] s;
      s = f;
      s = s >>> n;
      return l ? (f << n) : s;
   endfunction : shx

   // ------------------------------------------------------------
   // Drivers: inputs change only at the falling edge
   // ------------------------------------------------------------
   task automatic ops(input logic [23:0] d, input logic [15:0] c);
      dm = d;
      cm = c;
      repeat (3) @(negedge clk);
   endtask : ops

   task automatic sh(input msh_mode_t m, input logic l, input logic [2:0] c, input logic b);
      mode = m;
      sl = l;
      sc = c;
      bsc = b;
      @(negedge clk);
   endtask : sh

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_select;
      bus = 24'hA00000;
      for (int i = 0; i < 4; i++)
      begin
         cfb = i[1];
         dfb = i[0];
         ops(24'h600000, 16'h4000);
         `CHK(prod, f_prod(dfb ? bus : dm, cfb ? bus[23:8] : cm));
      end
      // Bus times bus: one half squared gives one quarter
      bus = 24'h400000;
      ops(24'h000000, 16'h0000);
      `CHK(prod, 31'h08000000);
      cfb = 1'b0;
      dfb = 1'b0;
      ops(24'h800000, 16'h8000);
      `CHK(prod, 31'h20000000);
   endtask : t_select

   // Back-to-back operands, each product two cycles later
   task automatic t_pipe;
      for (int k = 0; k < 8; k++)
      begin
         if (k >= 2)
            `CHK(prod, f_prod(24'h800001 + 24'(k - 2) * 24'h0F0F0F, 16'h8001 + 16'(k - 2) * 16'h1357));
         dm = 24'h800001 + 24'(k) * 24'h0F0F0F;
         cm = 16'h8001 + 16'(k) * 16'h1357;
         @(negedge clk);
      end
   endtask : t_pipe

   // Every direct code, both directions, both sources; operands stay off the bus
   task automatic t_direct(input logic [23:0] d, input logic [15:0] c);
      ops(d, c);
      bus = 24'hC0FFEE;
      for (int s = 0; s < 2; s++)
         for (int l = 0; l < 2; l++)
            for (int c3 = 0; c3 < 8; c3++)
            begin
               sh(MSH_DIRECT, l[0], 3'(c3), s[0]);
               `CHK(sout, shx(s[0] ? fb(bus) : fr(f_prod(d, c)), l[0], AMT[c3]));
            end
   endtask : t_direct

   task automatic t_dpl;
      logic [30:0] p;
      p = f_prod(24'h3579BD, 16'h6ACF);
      ops(24'h3579BD, 16'h6ACF);
      sh(MSH_DPL, 1'b0, 3'h0, 1'b0);
      `CHK(sout, {13'h0000, p[14:0], 6'h00});
      sh(MSH_DIRECT, 1'b0, 3'h0, 1'b0);
      `CHK(sout, fr({p[30:6], 6'h00}));
      sh(MSH_DIRECT, 1'b0, 3'h0, 1'b0);
      `CHK(sout, fr(p));
   endtask : t_dpl

   // Named source is the bus, yet the accumulator must be used
   task automatic t_dpr;
      logic signed [33:0] s;
      bus = 24'h9ABCDE;
      acc_clr = 1'b1;
      sh(MSH_DIRECT, 1'b0, 3'h0, 1'b1);
      acc_clr = 1'b0;
      acc_en = 1'b1;
      sh(MSH_DIRECT, 1'b1, 3'h7, 1'b0);
      acc_en = 1'b0;
      sh(MSH_DPR, 1'b1, 3'h3, 1'b1);
      s = fb(bus);
      s = s >>> 15;
      s[5:0] = 6'h00;
      `CHK(sout, s);
   endtask : t_dpr

   // Count loads, overrides one step only, top bit ignored
   task automatic t_ind(input logic [4:0] n);
      logic [30:0] p;
      p = f_prod(24'hA5A5A5, 16'h7FFF);
      ops(24'hA5A5A5, 16'h7FFF);
      bus = {n, 19'h5A5A5};
      sis = 1'b1;
      sh(MSH_DIRECT, 1'b1, 3'h7, 1'b0);
      sis = 1'b0;
      `CHK(icnt, n);
      sh(MSH_DIRECT, 1'b1, 3'h7, 1'b0);
      `CHK(sout, shx(fr(p), 1'b0, n[3:0]));
      sh(MSH_DIRECT, 1'b1, 3'h7, 1'b0);
      `CHK(sout, shx(fr(p), 1'b1, 4'hF));
   endtask : t_ind

   // ------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // ------------------------------------------------------------
   task automatic end_sim;
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (5) @(negedge clk);
      `CHK(prod, 31'h00000000);
      `CHK(sout, 34'h000000000);
      rst_n = 1'b1;
      @(negedge clk);
      t_select();
      t_pipe();
      t_direct(24'h800000, 16'h8000);
      t_direct(24'hA5A5A5, 16'h7FFF);
      t_dpl();
      t_dpr();
      t_ind(5'h13);
      t_ind(5'h0F);
      end_sim();
   end

   // The sequence needs well under 400 cycles
   initial
   begin
      #60000;
      fail_count++;
      end_sim();
   end
endmodule : test_msh_top
